// >>> rtl/i2c_addressing_config.sv
// Register file and addressing control of the two-wire bus controller, reached over AXI4-Lite.
`timescale 1ns/100ps

// Functional notes
// - Slave-disable bit turns slave off when set; resets set.
// - Master-enable bit turns master role on when set; resets enabled.
// - Restart-permit bit allows repeated STARTs as master; resets allowed.
// - Master addressing bit picks 7-bit or 10-bit master transfers; resets 10-bit.
// - Slave addressing bit picks 7-bit or 10-bit slave answers; resets 10-bit.
// - Speed field: code 1 standard, code 2 fast; resets to code 2.
// - Special bit clear addresses normally; set performs the selected special command.
// - With special set, selector clear means General Call, set means START byte.
// - After General Call only writes; a read command sets the abort flag.
// - General Call mode lasts until software clears the special bit or sets the selector.
// - Ten-bit target address feeds every master transfer; resets 0x55.
// - Target address is ignored while a General Call is sent.
// - Own-address target allows simplex loopback only; master never transmits to itself while the slave is enabled.
// - Own slave address is ten bits, low seven under 7-bit; resets 0x55.
// - Own-address writes take effect only while the interface is disabled.
module i2c_addressing_config
  import i2c_cfg_pkg::*;
(
  // Clock and reset.
  input  wire logic                sys_clk_i,
  input  wire logic                rst_b_i,
  // AXI4-Lite write address and data.
  input  wire logic [31:0]         awaddr_i,
  input  wire logic                awvalid_i,
  output logic                     awready_o,
  input  wire logic [31:0]         wdata_i,
  input  wire logic [3:0]          wstrb_i,
  input  wire logic                wvalid_i,
  output logic                     wready_o,
  // AXI4-Lite write response.
  output logic [1:0]               bresp_o,
  output logic                     bvalid_o,
  input  wire logic                bready_i,
  // AXI4-Lite read.
  input  wire logic [31:0]         araddr_i,
  input  wire logic                arvalid_i,
  output logic                     arready_o,
  output logic [31:0]              rdata_o,
  output logic [1:0]               rresp_o,
  output logic                     rvalid_o,
  input  wire logic                rready_i,
  // Toward the bus engine.
  output i2c_cfg_pkg::cfg_t        cfg_o,
  output i2c_cfg_pkg::cmd_t        cmd_o,
  output logic                     interface_enable_o,
  output logic                     transmit_abort_flag_o
);
  import i2c_cfg_pkg::*;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_have;
    logic [31:0] awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [15:0] con;
    logic [15:0] tar;
    logic [15:0] sar;
    logic        enable;
    logic        abort;
    cmd_t        cmd;
    cfg_t        cfg;
  } state_t;

  // Configuration outputs as they stand with the reset register values, except loopback, which resets 0 until the first decode.
  localparam cfg_t CFG_RST = '{master_en: 1'b1, slave_en: 1'b0, restart_en: 1'b1,
                               master_wide_addressing: 1'b1, slave_wide_addressing: 1'b1,
                               speed: SPEED_FAST, general_call: 1'b0, start_byte: 1'b0,
                               target_addr: TAR_RST[9:0], own_addr: SAR_RST[9:0], loopback: 1'b0};

  localparam state_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                con: CON_RST, tar: TAR_RST, sar: SAR_RST,
                                cfg: CFG_RST, default: '0};

  state_t q;
  state_t d;

  // Merge the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0])
      r[7:0] = wd[7:0];
    if (st[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  logic        wr_go;
  logic        wr_hit;
  logic        cmd_wr;
  logic        clr_abort;
  logic        set_abort;
  logic        gc_mode;
  logic        self_tx;
  logic [15:0] rd_word;
  logic        rd_hit;

  // Next-state logic for the bus slave, registers and command path.
  always_comb
  begin
    d         = q;
    wr_go     = q.aw_have && q.w_have && !q.bvalid;
    wr_hit    = 1'b1;
    cmd_wr    = 1'b0;
    clr_abort = 1'b0;
    set_abort = 1'b0;
    rd_word   = '0;
    rd_hit    = 1'b1;
    gc_mode   = q.tar[TAR_SPECIAL] && !q.tar[TAR_GC_OR_SB];
    self_tx   = !q.tar[TAR_SPECIAL] && (q.cfg.target_addr == q.cfg.own_addr);
    d.cmd.valid = 1'b0;

    // Address and data are taken independently, in either order.
    if (awvalid_i && q.awready)
    begin
      d.aw_have = 1'b1;
      d.awaddr  = awaddr_i;
    end
    if (wvalid_i && q.wready)
    begin
      d.w_have = 1'b1;
      d.wdata  = wdata_i;
      d.wstrb  = wstrb_i;
    end

    // Register write once both halves are held.
    if (wr_go)
    begin
      case (q.awaddr)
        BUS_CONTROL_ADDR:
          d.con = merge16(q.con, q.wdata, q.wstrb) & CON_MASK;
        TARGET_ADDR_ADDR:
          d.tar = merge16(q.tar, q.wdata, q.wstrb) & TAR_MASK;
        OWN_SLAVE_ADDR:
          if (!q.enable)
            d.sar = merge16(q.sar, q.wdata, q.wstrb) & SAR_MASK;
        IF_ENABLE_ADDR:
          if (q.wstrb[0])
            d.enable = q.wdata[0];
        EVENT_STATUS_ADDR:
          clr_abort = q.wstrb[0] && q.wdata[STAT_ABORT_BIT];
        MASTER_CMD_ADDR:
          cmd_wr = q.enable && q.cfg.master_en;
        default:
          wr_hit = 1'b0;
      endcase
      d.bvalid = 1'b1;
      d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Master command: reads after a General Call abort, as do writes to our own address while the slave is on.
    if (cmd_wr)
    begin
      if (q.wdata[CMD_READ_BIT] && gc_mode)
        set_abort = 1'b1;
      else if (!q.wdata[CMD_READ_BIT] && self_tx && q.cfg.slave_en)
        set_abort = 1'b1;
      else
      begin
        d.cmd.valid = 1'b1;
        d.cmd.read  = q.wdata[CMD_READ_BIT];
        d.cmd.data  = q.wdata[7:0];
      end
    end

    // A fresh abort in the same cycle as its clear is kept.
    d.abort = set_abort || (q.abort && !clr_abort);

    // Write response retires and frees both halves.
    if (q.bvalid && bready_i)
    begin
      d.bvalid  = 1'b0;
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // Read path: one cycle from address to data.
    case (araddr_i)
      BUS_CONTROL_ADDR:  rd_word = q.con;
      TARGET_ADDR_ADDR:  rd_word = q.tar;
      OWN_SLAVE_ADDR:    rd_word = q.sar;
      IF_ENABLE_ADDR:    rd_word = {15'h0000, q.enable};
      EVENT_STATUS_ADDR: rd_word = 16'(q.abort) << STAT_ABORT_BIT;
      MASTER_CMD_ADDR:   rd_word = '0;
      default:           rd_hit  = 1'b0;
    endcase
    if (arvalid_i && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rdata  = {16'h0000, rd_word};
      d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (q.rvalid && rready_i)
      d.rvalid = 1'b0;
    d.arready = !d.rvalid;

    // Configuration decode from the next register values.
    d.cfg.master_en              = d.con[CON_MASTER_EN];
    d.cfg.slave_en               = !d.con[CON_SLAVE_DIS];
    d.cfg.restart_en             = d.con[CON_RESTART];
    d.cfg.master_wide_addressing = d.con[CON_MST_WIDE];
    d.cfg.slave_wide_addressing  = d.con[CON_SLV_WIDE];
    // Undefined speed codes fall back to the nearest defined one.
    case (d.con[CON_SPEED_LO +: 2])
      SPEED_STD, 2'h0: d.cfg.speed = SPEED_STD;
      default:         d.cfg.speed = SPEED_FAST;
    endcase
    d.cfg.general_call = d.tar[TAR_SPECIAL] && !d.tar[TAR_GC_OR_SB];
    d.cfg.start_byte   = d.tar[TAR_SPECIAL] && d.tar[TAR_GC_OR_SB];
    // The engine sees no address during a General Call.
    d.cfg.target_addr  = d.cfg.general_call ? '0 : d.tar[9:0];
    d.cfg.own_addr     = d.con[CON_SLV_WIDE] ? d.sar[9:0]
                                             : (d.sar[9:0] & NARROW_MASK);
    d.cfg.loopback     = !d.tar[TAR_SPECIAL] && (d.tar[9:0] == d.sar[9:0]);
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      q <= ST_RST;
    else
      q <= d;
  end

  // Outputs straight from the state register.
  assign awready_o             = q.awready;
  assign wready_o              = q.wready;
  assign bvalid_o              = q.bvalid;
  assign bresp_o               = q.bresp;
  assign arready_o             = q.arready;
  assign rvalid_o              = q.rvalid;
  assign rdata_o               = q.rdata;
  assign rresp_o               = q.rresp;
  assign cfg_o                 = q.cfg;
  assign cmd_o                 = q.cmd;
  assign interface_enable_o    = q.enable;
  assign transmit_abort_flag_o = q.abort;

  // Sequences of a register write finishing at a given address.
  sequence s_write_to(logic [31:0] a);
    wr_go && (q.awaddr == a);
  endsequence

  sequence s_gc_read;
    cmd_wr && q.wdata[CMD_READ_BIT] && gc_mode;
  endsequence

  a_sar_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_write_to(OWN_SLAVE_ADDR) ##0 q.enable |=> $stable(q.sar))
    else $error("own address changed while interface enabled");

  a_gc_read_abort: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_gc_read |=> transmit_abort_flag_o && !cmd_o.valid)
    else $error("read after general call did not abort");

  // A control write that carries the low byte lane.
  sequence s_con_write;
    s_write_to(BUS_CONTROL_ADDR) ##0 q.wstrb[0];
  endsequence

  // Only a write to the status word may drop the flag; anything else leaves it standing.
  a_abort_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    q.abort && !(wr_go && (q.awaddr == EVENT_STATUS_ADDR)) |=> q.abort)
    else $error("abort flag dropped without a clear");

  a_slave_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_write_to(BUS_CONTROL_ADDR) ##0 q.wstrb[0] |=> cfg_o.slave_en == !$past(q.wdata[CON_SLAVE_DIS]))
    else $error("slave role does not follow its disable bit");

  a_master_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_write_to(BUS_CONTROL_ADDR) ##0 q.wstrb[0] |=> cfg_o.master_en == $past(q.wdata[CON_MASTER_EN]))
    else $error("master role does not follow its enable bit");

  a_speed_legal: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (cfg_o.speed == SPEED_STD) || (cfg_o.speed == SPEED_FAST))
    else $error("speed output holds an undefined code");

  a_gc_no_target: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    cfg_o.general_call |-> (cfg_o.target_addr == '0) && !cfg_o.start_byte)
    else $error("target address driven during general call");

  a_narrow_own: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !cfg_o.slave_wide_addressing |-> (cfg_o.own_addr[9:7] == '0))
    else $error("upper own address bits used in 7-bit mode");

  a_gc_persists: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(cfg_o.general_call) |-> !q.tar[TAR_SPECIAL] || q.tar[TAR_GC_OR_SB])
    else $error("general call mode left with its selection still standing");

  a_write_answer: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_go |=> bvalid_o [*1] ##0 (bresp_o == RESP_OKAY || bresp_o == RESP_SLVERR))
    else $error("write not answered one cycle after both halves");

  // Restart and addressing bits follow the low byte of each control write.
  a_restart_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_con_write |=> cfg_o.restart_en == $past(q.wdata[CON_RESTART]))
    else $error("restart permission does not follow its bit");

  a_mwide_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_con_write |=> cfg_o.master_wide_addressing == $past(q.wdata[CON_MST_WIDE]))
    else $error("master addressing width does not follow its bit");

  a_swide_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_con_write |=> cfg_o.slave_wide_addressing == $past(q.wdata[CON_SLV_WIDE]))
    else $error("slave addressing width does not follow its bit");

  // A start byte is shown only while both special bits are set.
  a_start_byte_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    cfg_o.start_byte |-> q.tar[TAR_SPECIAL] && q.tar[TAR_GC_OR_SB])
    else $error("start byte shown without its selection");

  // Outside a General Call the engine gets the stored target unchanged.
  a_target_passes: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !cfg_o.general_call |-> (cfg_o.target_addr == q.tar[9:0]))
    else $error("target address to engine differs from the register");

  // A write command aimed at our own slave is refused, not issued, while the slave is on.
  a_self_tx_abort: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    cmd_wr && !q.wdata[CMD_READ_BIT] && self_tx && q.cfg.slave_en |=> transmit_abort_flag_o && !cmd_o.valid)
    else $error("write to own address was issued");

  // A full own-address write lands while the interface is off.
  a_sar_accepts: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_write_to(OWN_SLAVE_ADDR) ##0 !q.enable ##0 (q.wstrb[1:0] == 2'h3)
      |=> q.sar == ($past(q.wdata[15:0]) & SAR_MASK))
    else $error("own address write lost while interface disabled");

  // Master commands reach the engine as single-cycle pulses; the response phase keeps them apart.
  a_cmd_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    cmd_o.valid |=> !cmd_o.valid)
    else $error("command valid held longer than one cycle");

endmodule

// >>> include/i2c_cfg_pkg.sv
// Package with register map, field layout and carrier types of the I2C addressing configuration block.
package i2c_cfg_pkg;

  // Byte addresses of the bus-visible registers.
  localparam logic [31:0] BUS_CONTROL_ADDR  = 32'h5000_1300;
  localparam logic [31:0] TARGET_ADDR_ADDR  = 32'h5000_1304;
  localparam logic [31:0] OWN_SLAVE_ADDR    = 32'h5000_1308;
  localparam logic [31:0] IF_ENABLE_ADDR    = 32'h5000_1340;
  localparam logic [31:0] EVENT_STATUS_ADDR = 32'h5000_1344;
  localparam logic [31:0] MASTER_CMD_ADDR   = 32'h5000_1348;

  // Reset values.
  localparam logic [15:0] CON_RST = 16'h007d;
  localparam logic [15:0] TAR_RST = 16'h0055;
  localparam logic [15:0] SAR_RST = 16'h0055;

  // Field positions in bus_control.
  localparam int CON_MASTER_EN  = 0;
  localparam int CON_SPEED_LO   = 1;
  localparam int CON_SLV_WIDE   = 3;
  localparam int CON_MST_WIDE   = 4;
  localparam int CON_RESTART    = 5;
  localparam int CON_SLAVE_DIS  = 6;
  localparam logic [15:0] CON_MASK = 16'h007f;

  // Field positions in target_address and own_slave_address.
  localparam int TAR_GC_OR_SB   = 10;
  localparam int TAR_SPECIAL    = 11;
  localparam logic [15:0] TAR_MASK  = 16'h0fff;
  localparam logic [15:0] SAR_MASK  = 16'h03ff;
  localparam logic [9:0]  NARROW_MASK = 10'h07f;

  // Field positions in the command and status words.
  localparam int CMD_READ_BIT   = 8;
  localparam int STAT_ABORT_BIT = 6;

  // Speed codes.
  localparam logic [1:0] SPEED_STD  = 2'h1;
  localparam logic [1:0] SPEED_FAST = 2'h2;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Configuration seen by the bus engine of the controller.
  typedef struct packed {
    logic       master_en;
    logic       slave_en;
    logic       restart_en;
    logic       master_wide_addressing;
    logic       slave_wide_addressing;
    logic [1:0] speed;
    logic       general_call;
    logic       start_byte;
    logic [9:0] target_addr;
    logic [9:0] own_addr;
    logic       loopback;
  } cfg_t;

  // One master command handed to the bus engine.
  typedef struct packed {
    logic       valid;
    logic       read;
    logic [7:0] data;
  } cmd_t;

endpackage

// >>> sim/engine_model.sv
// Behavioural model of the bus engine that takes the configuration and the master commands.
`timescale 1ns/100ps
module engine_model
  import i2c_cfg_pkg::*;
(
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  // From the configuration block.
  input  wire i2c_cfg_pkg::cfg_t cfg_i,
  input  wire i2c_cfg_pkg::cmd_t cmd_i,
  // Observation toward the testbench.
  output int                     n_cmd_o,
  output i2c_cfg_pkg::cmd_t      last_cmd_o
);
  // A command is taken at every edge where valid is high; a real engine would queue it, a count is enough here.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      n_cmd_o <= 0;
      last_cmd_o <= '0;
    end
    else if (cmd_i.valid)
    begin
      n_cmd_o <= n_cmd_o + 1;
      last_cmd_o <= cmd_i;
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking testbench of the I2C addressing configuration block.
`timescale 1ns/100ps
module tb;
  import i2c_cfg_pkg::*;
  // Clock, reset and bus drive.
  logic        sys_clk_i, rst_b_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic [31:0] awaddr_i, wdata_i, araddr_i;
  logic [3:0]  wstrb_i;
  // Design outputs.
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, interface_enable_o, transmit_abort_flag_o;
  logic [1:0]  bresp_o, rresp_o;
  logic [31:0] rdata_o;
  cfg_t        cfg;
  cmd_t        cmd, last_cmd;
  int          n_cmd, n_fail, n_checks;
  logic [6:0]  ctl_bits;
  logic [11:0] adr_bits;
  // Compact views of the configuration so one compare covers several fields.
  assign ctl_bits = {cfg.slave_en, cfg.master_en, cfg.restart_en, cfg.master_wide_addressing,
                     cfg.slave_wide_addressing, cfg.speed};
  assign adr_bits = {cfg.general_call, cfg.start_byte, cfg.target_addr};

  // Device under test and the engine on its far side.
  i2c_addressing_config i_dut (.sys_clk_i, .rst_b_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
    .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o,
    .rresp_o, .rvalid_o, .rready_i, .cfg_o(cfg), .cmd_o(cmd), .interface_enable_o, .transmit_abort_flag_o);
  engine_model i_engine (.sys_clk_i, .rst_b_i, .cfg_i(cfg), .cmd_i(cmd), .n_cmd_o(n_cmd), .last_cmd_o(last_cmd));

  // Clock generator.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Compares one value; case inequality keeps unknowns from matching.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    begin
      n_checks++;
      if (got !== exp)
      begin
        n_fail++;
        $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
    end
  endtask

  // Write; handshakes are judged at the falling edge, where the registered readies are settled.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] r;
    begin
      b_ok = 1'b0;
      @(posedge sys_clk_i);
      awaddr_i <= a;
      wdata_i <= d;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      while (!b_ok)
      begin
        @(negedge sys_clk_i);
        aw_ok = awready_o & awvalid_i;
        w_ok = wready_o & wvalid_i;
        b_ok = bvalid_o;
        r = bresp_o;
        @(posedge sys_clk_i);
        if (aw_ok)
          awvalid_i <= 1'b0;
        if (w_ok)
          wvalid_i <= 1'b0;
      end
      bready_i <= 1'b0;
      chk(32'(r), 32'(er), "write response");
    end
  endtask

  // Read and compare data and response.
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_ok, r_ok;
    logic [31:0] d;
    logic [1:0] r;
    begin
      r_ok = 1'b0;
      @(posedge sys_clk_i);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      while (!r_ok)
      begin
        @(negedge sys_clk_i);
        ar_ok = arready_o & arvalid_i;
        r_ok = rvalid_o;
        d = rdata_o;
        r = rresp_o;
        @(posedge sys_clk_i);
        if (ar_ok)
          arvalid_i <= 1'b0;
      end
      rready_i <= 1'b0;
      chk(d, ed, "read data");
      chk(32'(r), 32'(er), "read response");
    end
  endtask

  // Issues a master command and judges the engine pulse and the abort flag.
  task automatic cmd_chk(input logic [31:0] d, input int pulse, input logic abort);
    int n0;
    begin
      n0 = n_cmd;
      wr(MASTER_CMD_ADDR, d, RESP_OKAY);
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk(32'(n_cmd - n0), 32'(pulse), "command count");
      chk(32'(transmit_abort_flag_o), 32'(abort), "abort flag");
      if (pulse == 1)
        chk(32'({last_cmd.read, last_cmd.data}), d & 32'h0000_01ff, "command word");
    end
  endtask

  // Reset values at registers and configuration outputs.
  task automatic t_reset();
    begin
      rd(BUS_CONTROL_ADDR, 32'h0000_007d, RESP_OKAY);
      rd(TARGET_ADDR_ADDR, 32'h0000_0055, RESP_OKAY);
      rd(OWN_SLAVE_ADDR, 32'h0000_0055, RESP_OKAY);
      rd(32'h5000_13fc, 32'h0000_0000, RESP_SLVERR);
      chk(32'(ctl_bits), 32'h0000_003e, "reset control");
      chk(32'(adr_bits), 32'h0000_0055, "reset target");
      chk(32'({cfg.loopback, cfg.own_addr}), 32'h0000_0455, "reset own address");
    end
  endtask

  // Role, addressing and speed fields; speed codes 0 and 3 are written on purpose.
  task automatic t_control();
    begin
      wr(OWN_SLAVE_ADDR, 32'h0000_03d5, RESP_OKAY);
      wr(BUS_CONTROL_ADDR, 32'h0000_0002, RESP_OKAY);
      chk(32'(ctl_bits), 32'h0000_0041, "narrow slave control");
      chk(32'(cfg.own_addr), 32'h0000_0055, "narrow own address");
      wr(BUS_CONTROL_ADDR, 32'h0000_000a, RESP_OKAY);
      chk(32'(ctl_bits), 32'h0000_0045, "wide slave control");
      chk(32'(cfg.own_addr), 32'h0000_03d5, "wide own address");
      for (int c = 0; c < 4; c++)
      begin
        wr(BUS_CONTROL_ADDR, 32'h0000_0040 | 32'(c << 1), RESP_OKAY);
        chk(32'(cfg.speed), (c == 0) ? 32'h1 : (c == 3) ? 32'h2 : 32'(c), "speed");
        rd(BUS_CONTROL_ADDR, 32'h0000_0040 | 32'(c << 1), RESP_OKAY);
      end
      wr(BUS_CONTROL_ADDR, 32'h0000_0045, RESP_OKAY);
      chk(32'(ctl_bits), 32'h0000_0022, "master control");
    end
  endtask

  // General Call, START byte and the return to normal addressing.
  task automatic t_special();
    begin
      wr(IF_ENABLE_ADDR, 32'h0000_0001, RESP_OKAY);
      chk(32'(interface_enable_o), 32'h1, "enable");
      wr(TARGET_ADDR_ADDR, 32'h0000_0955, RESP_OKAY);
      chk(32'(adr_bits), 32'h0000_0800, "general call");
      cmd_chk(32'h0000_0100, 0, 1'b1);
      cmd_chk(32'h0000_00a5, 1, 1'b1);
      wr(EVENT_STATUS_ADDR, 32'h0000_0040, RESP_OKAY);
      chk(32'(transmit_abort_flag_o), 32'h0, "abort cleared");
      wr(TARGET_ADDR_ADDR, 32'h0000_0d23, RESP_OKAY);
      chk(32'(adr_bits), 32'h0000_0523, "start byte");
      cmd_chk(32'h0000_0100, 1, 1'b0);
      wr(TARGET_ADDR_ADDR, 32'h0000_0523, RESP_OKAY);
      chk(32'(adr_bits), 32'h0000_0123, "normal target");
    end
  endtask

  // Own address is frozen while the interface is enabled.
  task automatic t_lock();
    begin
      wr(OWN_SLAVE_ADDR, 32'h0000_0077, RESP_OKAY);
      rd(OWN_SLAVE_ADDR, 32'h0000_03d5, RESP_OKAY);
      chk(32'(cfg.own_addr), 32'h0000_0055, "frozen own address");
    end
  endtask

  // Target equal to own address: slave and master both on, breaking the advice on purpose.
  task automatic t_loop();
    begin
      wr(TARGET_ADDR_ADDR, 32'h0000_03d5, RESP_OKAY);
      wr(BUS_CONTROL_ADDR, 32'h0000_001d, RESP_OKAY);
      chk(32'(cfg.loopback), 32'h1, "loopback");
      cmd_chk(32'h0000_0011, 0, 1'b1);
      wr(EVENT_STATUS_ADDR, 32'h0000_0040, RESP_OKAY);
      cmd_chk(32'h0000_0100, 1, 1'b0);
      wr(IF_ENABLE_ADDR, 32'h0000_0000, RESP_OKAY);
      cmd_chk(32'h0000_0022, 0, 1'b0);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    begin
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Main sequence; all inputs get a value at time zero.
  initial
  begin
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {awaddr_i, wdata_i, araddr_i} = '0;
    wstrb_i = 4'hf;
    rst_b_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_reset();
    t_control();
    t_special();
    t_lock();
    t_loop();
    final_report();
  end

  // Watchdog: the whole run needs far fewer than this many cycles.
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    final_report();
  end
endmodule
